// [alu_cfg.svh]
// register offsets, field positions and reset values of the alu core
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// =============================================================
// register byte offsets
`define ALU_OFS_DST     8'h00
`define ALU_OFS_DSTH    8'h04
`define ALU_OFS_SRC     8'h08
`define ALU_OFS_CMD     8'h0c
`define ALU_OFS_PLO     8'h10
`define ALU_OFS_PHI     8'h14
`define ALU_OFS_STATUS  8'h18

// =============================================================
// status and command word fields
`define ALU_FLG_C       0
`define ALU_FLG_Z       1
`define ALU_FLG_N       2
`define ALU_FLG_V       3
`define ALU_FLG_S       4
`define ALU_FLG_H       5
`define ALU_FLG_W       6
`define ALU_STAT_BUSY   8
`define ALU_CMD_LSB     0
`define ALU_CMD_W       4

// =============================================================
// reset values
`define ALU_FLG_RST     6'h00
`define ALU_RDATA_RST   32'h0000_0000

`endif

// [alu_pkg.sv]
// types and operation decoding shared by the alu core files
package alu_pkg;

    // =============================================================
    // operations
    typedef enum logic [3:0] {
        conjunction_reg,
        conjunction_immediate,
        disjunction_reg,
        disjunction_immediate,
        bit_set_immediate,
        bit_clear_immediate,
        zero_minus_test,
        ones_complement_op,
        arithmetic_invert_op,
        unsigned_product_op,
        signed_product_op,
        mixed_sign_product_op,
        fractional_unsigned_product,
        fractional_signed_product,
        fractional_mixed_product,
        word_immediate_subtract
    } alu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_FINISH
    } alu_state_t;

    // =============================================================
    // decoding
    function automatic logic is_product(input alu_op_t op);
        return op inside {unsigned_product_op, signed_product_op, mixed_sign_product_op,
            fractional_unsigned_product, fractional_signed_product, fractional_mixed_product};
    endfunction

    function automatic logic lhs_signed(input alu_op_t op);
        return op inside {signed_product_op, mixed_sign_product_op,
            fractional_signed_product, fractional_mixed_product};
    endfunction

    function automatic logic rhs_signed(input alu_op_t op);
        return op inside {signed_product_op, fractional_signed_product};
    endfunction

    function automatic logic is_fractional(input alu_op_t op);
        return op inside {fractional_unsigned_product, fractional_signed_product,
            fractional_mixed_product};
    endfunction

endpackage

// [alu_mul.sv]
// registered multiplier: unsigned, signed or mixed, plain or fractional
`timescale 1ns/1ps
module alu_mul #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // operands and mode
    input wire logic i_start,
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    input wire logic i_a_signed,
    input wire logic i_b_signed,
    input wire logic i_frac,
    // product
    output logic [2*W-1:0] o_prod,
    output logic o_carry
);
    localparam int PW = 2 * W + 2;

    generate
        if (W < 2) begin : g_bad_width
            $error("alu_mul: W must be at least 2");
        end
    endgenerate

    logic signed [W:0] a_ext;
    logic signed [W:0] b_ext;
    logic signed [PW-1:0] full;
    logic [2*W-1:0] raw;
    logic [2*W-1:0] prod_nxt;
    logic carry_nxt;

    // =============================================================
    // product
    always_comb begin
        a_ext = signed'({i_a_signed & i_a[W-1], i_a});
        b_ext = signed'({i_b_signed & i_b[W-1], i_b});
        full = PW'(a_ext) * PW'(b_ext);
        raw = full[2*W-1:0];
        prod_nxt = o_prod;
        carry_nxt = o_carry;
        if (i_start) begin
            // carry is the top bit before the fractional shift
            carry_nxt = raw[2*W-1];
            prod_nxt = i_frac ? {raw[2*W-2:0], 1'b0} : raw;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prod <= '0;
            o_carry <= 1'b0;
        end else begin
            o_prod <= prod_nxt;
            o_carry <= carry_nxt;
        end
    end
endmodule // alu_mul

// [alu_core.sv]
// alu core: logic, mask, test, word subtract and multiply behind an ahb-lite slave
//
// Overview of operation
// - AND combines the destination with a register or immediate, writes it back, sets Z N V, one clock.
// - OR combines the destination with a register or immediate, writes it back, sets Z N V, one clock.
// - bit set ORs an immediate mask into the destination and sets Z N V in one clock.
// - bit clear ANDs the destination with all-ones minus the mask and sets Z N V in one clock.
// - test ANDs a register with itself, keeps its value and sets Z N V from it in one clock.
// - every multiply puts its 2*DATA_W-bit product in PHI:PLO, fractional ones shifted left, sets only Z C, two clocks.
// - word subtract takes a register pair as one word, subtracts an immediate, writes both halves, two clocks.
`timescale 1ns/1ps
`include "alu_cfg.svh"
module alu_core #(
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp
);
    import alu_pkg::*;

    localparam int W = DATA_W;
    localparam logic [W-1:0] ONES = {W{1'b1}};
    localparam logic [W-1:0] ZERO = {W{1'b0}};

    generate
        // product pair and status word must fit one bus word
        if (W < 4 || W > 16) begin : g_bad_width
            $error("alu_core: DATA_W must lie in 4..16");
        end
    endgenerate

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // =============================================================
    // bus slave
    logic aph_wr_r, aph_wr_nxt;
    logic [7:0] aph_addr_r, aph_addr_nxt;
    logic [31:0] hrdata_nxt;
    logic [31:0] rd_val;
    logic take_addr;
    logic start;

    alu_state_t st_r, st_nxt;
    alu_op_t op_r, op_nxt;
    logic [W-1:0] dst_r, dst_nxt;
    logic [W-1:0] dsth_r, dsth_nxt;
    logic [W-1:0] src_r, src_nxt;
    logic [W-1:0] plo_r, plo_nxt;
    logic [W-1:0] phi_r, phi_nxt;
    logic [`ALU_FLG_W-1:0] flg_r, flg_nxt;
    logic brw_r, brw_nxt;

    assign take_addr = i_hsel && i_hready && i_htrans[1];
    // commands arriving while busy are dropped
    assign start = aph_wr_r && hit(aph_addr_r, `ALU_OFS_CMD) && st_r == ST_IDLE;

    always_comb begin
        rd_val = `ALU_RDATA_RST;
        unique case (i_haddr[7:0])
            `ALU_OFS_DST: rd_val = 32'(dst_r);
            `ALU_OFS_DSTH: rd_val = 32'(dsth_r);
            `ALU_OFS_SRC: rd_val = 32'(src_r);
            `ALU_OFS_CMD: rd_val = 32'(op_r);
            `ALU_OFS_PLO: rd_val = 32'(plo_r);
            `ALU_OFS_PHI: rd_val = 32'(phi_r);
            `ALU_OFS_STATUS: begin
                rd_val[`ALU_FLG_W-1:0] = flg_r;
                rd_val[`ALU_STAT_BUSY] = st_r != ST_IDLE;
            end
            default: rd_val = `ALU_RDATA_RST;
        endcase
        aph_wr_nxt = take_addr && i_hwrite;
        aph_addr_nxt = take_addr ? i_haddr[7:0] : aph_addr_r;
        hrdata_nxt = (take_addr && !i_hwrite) ? rd_val : o_hrdata;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            aph_wr_r <= 1'b0;
            aph_addr_r <= 8'h00;
            o_hrdata <= `ALU_RDATA_RST;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            aph_wr_r <= aph_wr_nxt;
            aph_addr_r <= aph_addr_nxt;
            o_hrdata <= hrdata_nxt;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // =============================================================
    // multiplier
    logic [2*W-1:0] prod;
    logic prod_carry;

    alu_mul #(
        .W(W)
    ) u_mul (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_start(st_r == ST_EXEC && is_product(op_r)),
        .i_a(dst_r),
        .i_b(src_r),
        .i_a_signed(lhs_signed(op_r)),
        .i_b_signed(rhs_signed(op_r)),
        .i_frac(is_fractional(op_r)),
        .o_prod(prod),
        .o_carry(prod_carry)
    );

    // =============================================================
    // datapath and sequencer
    logic [W-1:0] res;
    logic [`ALU_FLG_W-1:0] f1;
    logic [W:0] sub_lo;
    logic [W-1:0] sub_hi;

    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        dst_nxt = dst_r;
        dsth_nxt = dsth_r;
        src_nxt = src_r;
        plo_nxt = plo_r;
        phi_nxt = phi_r;
        flg_nxt = flg_r;
        brw_nxt = brw_r;
        res = dst_r;
        unique case (op_r)
            conjunction_reg, conjunction_immediate: res = dst_r & src_r;
            disjunction_reg, disjunction_immediate: res = dst_r | src_r;
            bit_set_immediate: res = dst_r | src_r;
            bit_clear_immediate: res = dst_r & (ONES - src_r);
            zero_minus_test: res = dst_r & dst_r;
            ones_complement_op: res = ONES - dst_r;
            arithmetic_invert_op: res = ZERO - dst_r;
            unsigned_product_op, signed_product_op, mixed_sign_product_op,
            fractional_unsigned_product, fractional_signed_product,
            fractional_mixed_product, word_immediate_subtract: res = dst_r;
        endcase
        // one-clock ops keep carry and half-carry unless they own them
        f1 = flg_r;
        f1[`ALU_FLG_Z] = res == ZERO;
        f1[`ALU_FLG_N] = res[W-1];
        f1[`ALU_FLG_V] = 1'b0;
        if (op_r == ones_complement_op) begin
            f1[`ALU_FLG_C] = 1'b1;
        end
        if (op_r == arithmetic_invert_op) begin
            f1[`ALU_FLG_C] = res != ZERO;
            f1[`ALU_FLG_V] = res == {1'b1, {(W-1){1'b0}}};
            f1[`ALU_FLG_H] = res[3] | dst_r[3];
        end
        f1[`ALU_FLG_S] = f1[`ALU_FLG_N] ^ f1[`ALU_FLG_V];
        // word subtract runs low byte first, borrow carried between clocks
        sub_lo = {1'b0, dst_r} - {1'b0, src_r};
        sub_hi = dsth_r - W'(brw_r);
        unique case (st_r)
            ST_IDLE: begin
                if (aph_wr_r && hit(aph_addr_r, `ALU_OFS_DST)) dst_nxt = i_hwdata[W-1:0];
                if (aph_wr_r && hit(aph_addr_r, `ALU_OFS_DSTH)) dsth_nxt = i_hwdata[W-1:0];
                if (aph_wr_r && hit(aph_addr_r, `ALU_OFS_SRC)) src_nxt = i_hwdata[W-1:0];
                if (aph_wr_r && hit(aph_addr_r, `ALU_OFS_STATUS)) begin
                    flg_nxt = i_hwdata[`ALU_FLG_W-1:0];
                end
                if (start) begin
                    op_nxt = alu_op_t'(i_hwdata[`ALU_CMD_LSB +: `ALU_CMD_W]);
                    st_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (is_product(op_r)) begin
                    st_nxt = ST_FINISH;
                end else if (op_r == word_immediate_subtract) begin
                    dst_nxt = sub_lo[W-1:0];
                    brw_nxt = sub_lo[W];
                    st_nxt = ST_FINISH;
                end else begin
                    dst_nxt = res;
                    flg_nxt = f1;
                    st_nxt = ST_IDLE;
                end
            end
            ST_FINISH: begin
                st_nxt = ST_IDLE;
                if (is_product(op_r)) begin
                    plo_nxt = prod[W-1:0];
                    phi_nxt = prod[2*W-1:W];
                    flg_nxt[`ALU_FLG_C] = prod_carry;
                    flg_nxt[`ALU_FLG_Z] = prod == {(2*W){1'b0}};
                end else begin
                    dsth_nxt = sub_hi;
                    flg_nxt[`ALU_FLG_N] = sub_hi[W-1];
                    flg_nxt[`ALU_FLG_V] = dsth_r[W-1] & ~sub_hi[W-1];
                    flg_nxt[`ALU_FLG_C] = sub_hi[W-1] & ~dsth_r[W-1];
                    flg_nxt[`ALU_FLG_Z] = sub_hi == ZERO && dst_r == ZERO;
                    flg_nxt[`ALU_FLG_S] = sub_hi[W-1] ^ (dsth_r[W-1] & ~sub_hi[W-1]);
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= ST_IDLE;
            op_r <= conjunction_reg;
            dst_r <= '0;
            dsth_r <= '0;
            src_r <= '0;
            plo_r <= '0;
            phi_r <= '0;
            flg_r <= `ALU_FLG_RST;
            brw_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            dst_r <= dst_nxt;
            dsth_r <= dsth_nxt;
            src_r <= src_nxt;
            plo_r <= plo_nxt;
            phi_r <= phi_nxt;
            flg_r <= flg_nxt;
            brw_r <= brw_nxt;
        end
    end

    // =============================================================
    // assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    logic exec;
    assign exec = st_r == ST_EXEC;

    sequence seq_long_done;
        (st_r == ST_FINISH) ##1 (st_r == ST_IDLE);
    endsequence

    AST_AND_ONE_CLOCK: assert property (exec && (op_r == conjunction_reg ||
        op_r == conjunction_immediate) |=>
        st_r == ST_IDLE && dst_r == ($past(dst_r) & $past(src_r)) && !flg_r[`ALU_FLG_V])
        else $error("and result or timing wrong");
    AST_OR_ONE_CLOCK: assert property (exec && (op_r == disjunction_reg ||
        op_r == disjunction_immediate) |=> dst_r == ($past(dst_r) | $past(src_r))
        && flg_r[`ALU_FLG_Z] == (dst_r == ZERO))
        else $error("or result wrong");
    AST_BIT_SET: assert property (exec && op_r == bit_set_immediate |=>
        (dst_r & $past(src_r)) == $past(src_r) && flg_r[`ALU_FLG_N] == dst_r[W-1])
        else $error("bit set left a mask bit low");
    AST_BIT_CLEAR: assert property (exec && op_r == bit_clear_immediate |=>
        (dst_r & $past(src_r)) == ZERO && (dst_r | $past(src_r)) == ($past(dst_r) | $past(src_r)))
        else $error("bit clear result wrong");
    AST_TEST_KEEPS: assert property (exec && op_r == zero_minus_test |=>
        dst_r == $past(dst_r) && flg_r[`ALU_FLG_Z] == (dst_r == ZERO) && !flg_r[`ALU_FLG_V])
        else $error("test changed value or flags wrong");
    AST_PRODUCT_TWO: assert property (exec && is_product(op_r) |-> ##1 seq_long_done
        ##0 (flg_r[`ALU_FLG_Z] == ({phi_r, plo_r} == {(2*W){1'b0}})
        && flg_r[`ALU_FLG_N] == $past(flg_r[`ALU_FLG_N], 2)))
        else $error("product did not finish in two clocks");
    AST_WORD_SUB: assert property (exec && op_r == word_immediate_subtract |->
        ##1 seq_long_done ##0 ({dsth_r, dst_r} == {$past(dsth_r, 2), $past(dst_r, 2)}
        - {ZERO, $past(src_r, 2)}))
        else $error("word subtract result wrong");
    AST_NEGATE: assert property (exec && op_r == arithmetic_invert_op |=>
        dst_r == ZERO - $past(dst_r) && flg_r[`ALU_FLG_C] == (dst_r != ZERO))
        else $error("negation result or carry wrong");
    AST_CMD_LAUNCH: assert property (start |=> exec)
        else $error("command not launched");
endmodule // alu_core

// [alu_host_model.sv]
// bus-side partner: ahb-lite master standing in for decoder and register file
`timescale 1ns/1ps
module alu_host_model (
    // clock and bus answer
    input wire logic i_mclk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // bus request
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    // =============================================================
    // idle bus at time zero
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0000_0000;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0000_0000;
    end

    // =============================================================
    // waits for hready at a rising edge; only the bench watchdog ends a dead wait
    task automatic wait_ready();
        do begin
            @(posedge i_mclk);
        end while (i_hready !== 1'b1);
    endtask

    // one single word transfer; read data is taken at the edge ending the data phase
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_mclk);
        o_hsel <= 1'b1;
        o_haddr <= a;
        o_htrans <= 2'h2;
        o_hwrite <= wr;
        wait_ready();
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= wr ? d : 32'h0000_0000;
        wait_ready();
        q = i_hrdata;
    endtask
endmodule // alu_host_model

// [eight_bit_logic_multiply_alu_bench.sv]
// self-checking bench of the alu core over its ahb-lite port
`timescale 1ns/1ps
`include "alu_cfg.svh"
module eight_bit_logic_multiply_alu_bench;
    import alu_pkg::*;
    // =============================================================
    // bench signals
    localparam logic [31:0] A_DST = {24'h0, `ALU_OFS_DST};
    localparam logic [31:0] A_DSTH = {24'h0, `ALU_OFS_DSTH};
    localparam logic [31:0] A_SRC = {24'h0, `ALU_OFS_SRC};
    localparam logic [31:0] A_CMD = {24'h0, `ALU_OFS_CMD};
    localparam logic [31:0] A_PLO = {24'h0, `ALU_OFS_PLO};
    localparam logic [31:0] A_PHI = {24'h0, `ALU_OFS_PHI};
    localparam logic [31:0] A_STAT = {24'h0, `ALU_OFS_STATUS};
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    int errors = 0;
    int checks_done = 0;

    typedef struct {
        alu_op_t op;
        logic [7:0] dst, dsth, src, lo, hi;
        logic [3:0] fl;
        logic [1:0] sel;
    } row_t;
    // flags column is v n z c; carry preset to 1 so kept carry shows
    row_t rows [16] = '{
        '{conjunction_immediate, 8'ha5, 8'h00, 8'h0f, 8'h05, 8'h00, 4'h1, 2'd0},
        '{conjunction_reg, 8'hf0, 8'h00, 8'h0f, 8'h00, 8'h00, 4'h3, 2'd0},
        '{disjunction_reg, 8'h80, 8'h00, 8'h01, 8'h81, 8'h00, 4'h5, 2'd0},
        '{disjunction_immediate, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 4'h3, 2'd0},
        '{bit_set_immediate, 8'h10, 8'h00, 8'hc0, 8'hd0, 8'h00, 4'h5, 2'd0},
        '{bit_clear_immediate, 8'hff, 8'h00, 8'h0f, 8'hf0, 8'h00, 4'h5, 2'd0},
        '{zero_minus_test, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 4'h5, 2'd0},
        '{ones_complement_op, 8'h55, 8'h00, 8'h00, 8'haa, 8'h00, 4'h5, 2'd0},
        '{arithmetic_invert_op, 8'h80, 8'h00, 8'h00, 8'h80, 8'h00, 4'hd, 2'd0},
        '{unsigned_product_op, 8'hff, 8'h00, 8'hff, 8'h01, 8'hfe, 4'h1, 2'd1},
        '{signed_product_op, 8'hff, 8'h00, 8'h01, 8'hff, 8'hff, 4'h1, 2'd1},
        '{mixed_sign_product_op, 8'hff, 8'h00, 8'hff, 8'h01, 8'hff, 4'h1, 2'd1},
        '{fractional_unsigned_product, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 4'h0, 2'd1},
        '{fractional_signed_product, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 4'h0, 2'd1},
        '{fractional_mixed_product, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00, 4'h2, 2'd1},
        '{word_immediate_subtract, 8'h00, 8'h00, 8'h01, 8'hff, 8'hff, 4'h5, 2'd2}
    };

    always #20 i_mclk = ~i_mclk;

    alu_core #(.DATA_W(8)) DUT (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp)
    );

    alu_host_model u_host (
        .i_mclk(i_mclk), .i_hready(hreadyout), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata)
    );

    // =============================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        u_host.xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        u_host.xfer(1'b0, a, 32'h0, d);
    endtask

    // polling instead of fixed waits: capture edge may hide a same-edge result
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            rd(A_STAT, s);
            n++;
        end while (s[`ALU_STAT_BUSY] !== 1'b0 && n < 20);
        // a poll limit that runs out is a mismatch
        chk("busy cleared", {31'h0, s[`ALU_STAT_BUSY]}, 32'h0);
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =============================================================
    // watchdog: the tests need a few hundred cycles
    initial begin
        #800000;
        errors++;
        give_verdict();
    end

    // =============================================================
    // main sequence
    initial begin
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(negedge i_mclk);
        chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        chk("hresp", {31'h0, hresp}, 32'h0);
        rd(A_STAT, q);
        chk("status reset", q, 32'h0);
        rd(A_CMD, q);
        chk("cmd reset", q, 32'h0);
        foreach (rows[i]) begin
            wr(A_DST, {24'h0, rows[i].dst});
            wr(A_DSTH, {24'h0, rows[i].dsth});
            wr(A_SRC, {24'h0, rows[i].src});
            wr(A_STAT, 32'h21);
            wr(A_CMD, {28'h0, rows[i].op});
            wait_idle();
            rd(rows[i].sel == 2'd1 ? A_PLO : A_DST, q);
            chk(rows[i].op.name(), q, {24'h0, rows[i].lo});
            if (rows[i].sel != 2'd0) begin
                rd(rows[i].sel == 2'd1 ? A_PHI : A_DSTH, q);
                chk("upper half", q, {24'h0, rows[i].hi});
            end
            rd(A_STAT, q);
            chk("flags", {28'h0, q[3:0]}, {28'h0, rows[i].fl});
        end
        // one-clock op is over before a back-to-back write lands
        wr(A_DST, 32'h0f);
        wr(A_SRC, 32'hf0);
        wr(A_CMD, {28'h0, disjunction_reg});
        wr(A_DST, 32'h3c);
        rd(A_DST, q);
        chk("dst after one-clock op", q, 32'h3c);
        // two-clock op is still busy at the next capture edge
        wr(A_CMD, {28'h0, unsigned_product_op});
        rd(A_STAT, q);
        chk("busy during product", {31'h0, q[`ALU_STAT_BUSY]}, 32'h1);
        rd(A_STAT, q);
        rd(A_STAT, q);
        chk("idle after product", {31'h0, q[`ALU_STAT_BUSY]}, 32'h0);
        // unmapped place: reads zero, writes dropped, always okay
        wr(32'h40, 32'hffff_ffff);
        rd(32'h40, q);
        chk("unmapped", q, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        // reset in the middle of a product
        wr(A_CMD, {28'h0, signed_product_op});
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(A_PLO, q);
        chk("product after reset", q, 32'h0);
        rd(A_STAT, q);
        chk("status after reset", q, 32'h0);
        give_verdict();
    end
endmodule // eight_bit_logic_multiply_alu_bench
